// ---- src/pcs_buffer.sv ----
// Two-entry valid/ready buffer for the word stream.
// Assumes both sides run on clk_sys with the synchronised reset.
`timescale 1ns/10ps
module pcs_buffer
   import pcs_pkg::*;
#(
   parameter int WIDTH = PCS_BUF_W,
   parameter int DEPTH = PCS_BUF_DEPTH
)
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // Filling side
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);

   // ************************************************************
   // Storage and pointers
   // ************************************************************
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   wire              push;
   wire              pop;

   // Handshakes
   assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rd_q];

   // Entry writes
   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end

   // Pointer and fill count
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   buf_no_over_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cnt_q <= (PW+1)'(DEPTH))
      else $error("buffer overfilled");
   buf_full_stall_a: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      (cnt_q == (PW+1)'(DEPTH)) |-> !in_ready)
      else $error("full buffer accepts word");

endmodule : pcs_buffer

// ---- src/pcs_checksum.sv ----
// Program image checksum accumulator.
// Assumes a sequencer streams words in order with valid/ready.
//
// Operation
// RL1: Sum program, masked config, ID if protected.
// RL2: Result is low sixteen bits of sum.
// RL3: Data EEPROM words never change sum.
// RL4: Program memory added one 16-bit word each.
// RL5: Sequencer presents all program words from zero.
// RL6: Carries out of bit 15 dropped.
// RL7: Config byte ANDed with its indexed mask.
// RL8: Mask zero unimplemented, one selectable bits.
// RL9: Unimplemented config ones never affect sum.
// RL10: Protection bit zero means block protected.
// RL11: Fourteen masks as per-variant parameter table.
// RL12: Clear zeroes sum; done strobe shows result.
`timescale 1ns/10ps
module pcs_checksum
   import pcs_pkg::*;
#(
   parameter logic [111:0] MASK_TABLE = PCS_MASK_DEFAULT,
   parameter int           BLK_COUNT  = PCS_BLK_COUNT
)
(
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rstn,
   // Control
   input  wire logic                 clear,
   input  wire logic [BLK_COUNT-1:0] block_protect_bit,
   // Word stream
   input  wire logic                 word_valid,
   output      logic                 word_ready,
   input  wire logic [15:0]          word_data,
   input  wire logic [1:0]           word_kind,
   input  wire logic [PCS_IDX_W-1:0] config_index,
   input  wire logic                 word_last,
   // Result
   output      logic [15:0]          checksum,
   output      logic                 done
);

   // ************************************************************
   // Reset synchroniser
   // ************************************************************
   logic rst_meta_q;
   logic rst_n_q;

   // Release reset through two flops
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ************************************************************
   // Input stage
   // ************************************************************
   logic [PCS_BUF_W-1:0] in_word;
   logic [PCS_BUF_W-1:0] b_word;
   logic                 b_valid;
   logic                 b_ready;
   logic                 buf_in_ready;
   logic [PCS_IDX_W-1:0] cfg_idx_q;

   // Config index rides in data high byte
   assign in_word = {word_last, word_kind,
                     (word_kind == PCS_KIND_CONFIG) ?
                     {4'h0, config_index, word_data[7:0]} : word_data};
   // Intake closed in reset and during clear
   wire intake_ok;
   assign intake_ok  = rst_n_q && !clear;
   // Ready low until the synchroniser releases, so no word is lost
   assign word_ready = buf_in_ready && intake_ok;

   pcs_buffer #(
      .WIDTH (PCS_BUF_W),
      .DEPTH (PCS_BUF_DEPTH)
   ) u_buf (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n_q),
      .in_valid  (word_valid && intake_ok),
      .in_ready  (buf_in_ready),
      .in_data   (in_word),
      .out_valid (b_valid),
      .out_ready (b_ready),
      .out_data  (b_word)
   );

   // ************************************************************
   // Field decode
   // ************************************************************
   wire [1:0]           f_kind;
   wire                 f_last;
   wire [15:0]          f_data;
   wire [PCS_IDX_W-1:0] f_idx;
   wire [7:0]           f_mask;
   wire [7:0]           f_cfg_masked;
   wire                 any_protect;
   wire                 idx_ok;
   logic [15:0]         addend;

   assign f_kind = b_word[PCS_F_KIND_LSB +: 2];
   assign f_last = b_word[PCS_F_LAST_BIT];
   assign f_data = b_word[PCS_F_DATA_LSB +: 16];
   assign f_idx  = f_data[11:8];
   assign idx_ok = (f_idx < PCS_IDX_W'(PCS_CFG_COUNT));

   // One mask per config word, unpacked from the table [RL11]
   wire [7:0] mask_arr [PCS_CFG_COUNT];
   for (genvar g = 0; g < PCS_CFG_COUNT; g++)
   begin : g_mask
      assign mask_arr[g] = MASK_TABLE[g*8 +: 8];
   end

   // Mask selected by word index, none past the table [RL11]
   assign f_mask = idx_ok ? mask_arr[f_idx] : 8'h00;
   // Masking drops unimplemented bits [RL7] [RL8] [RL9]
   assign f_cfg_masked = f_data[7:0] & f_mask;
   // Any zero protection bit means protected [RL10]
   assign any_protect = ~&block_protect_bit;

   // Addend by word kind [RL1] [RL3] [RL4]
   always_comb
   begin
      addend = 16'h0000;
      case (f_kind)
         PCS_KIND_PROG:   addend = f_data;
         PCS_KIND_CONFIG: addend = {8'h00, f_cfg_masked};
         PCS_KIND_ID:     addend = any_protect ? f_data : 16'h0000;
         default:         addend = 16'h0000;
      endcase
   end

   // ************************************************************
   // Accumulator
   // ************************************************************
   logic [15:0] sum_q;
   logic [15:0] sum_d;
   logic [15:0] res_q;
   logic        done_q;
   wire         take;

   // Drain whenever not clearing
   assign b_ready = !clear;
   assign take    = b_valid && b_ready;
   // Carry out of bit 15 discarded [RL2] [RL6]
   assign sum_d = 16'(sum_q + addend);

   // Running sum with synchronous clear [RL12]
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
         sum_q <= PCS_SUM_RESET;
      else if (clear)
         sum_q <= PCS_SUM_RESET;
      else if (take)
         sum_q <= f_last ? PCS_SUM_RESET : sum_d;
   end

   // Result register and done strobe [RL12]
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         res_q  <= PCS_SUM_RESET;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= take && f_last && !clear;
         if (clear)
            res_q <= PCS_SUM_RESET;
         else if (take && f_last)
            res_q <= sum_d;
      end
   end

   assign checksum = res_q;
   assign done     = done_q;

   // Keep last config index seen for coverage
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
         cfg_idx_q <= '0;
      else if (take && f_kind == PCS_KIND_CONFIG)
         cfg_idx_q <= f_idx;
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n_q);

   eeprom_ignored_a: assert property ( // [RL3]
      take && f_kind == PCS_KIND_EEPROM && !f_last && !clear
      |=> sum_q == $past(sum_q))
      else $error("eeprom word changed sum");
   prog_word_add_a: assert property ( // [RL4]
      take && f_kind == PCS_KIND_PROG && !f_last && !clear
      |=> sum_q == 16'($past(sum_q) + $past(f_data)))
      else $error("program word not added whole");
   cfg_masked_a: assert property ( // [RL7]
      take && f_kind == PCS_KIND_CONFIG && !f_last && !clear
      |=> (16'(sum_q - $past(sum_q)) & ~{8'h00, $past(f_mask)}) == 16'h0)
      else $error("config bits outside mask added");
   unimpl_bits_a: assert property ( // [RL9]
      take && f_kind == PCS_KIND_CONFIG && !idx_ok && !f_last && !clear
      |=> sum_q == $past(sum_q))
      else $error("unmasked config byte added");
   id_gated_a: assert property ( // [RL1]
      take && f_kind == PCS_KIND_ID && !any_protect && !f_last && !clear
      |=> sum_q == $past(sum_q))
      else $error("id word added while unprotected");
   id_added_a: assert property ( // [RL10]
      take && f_kind == PCS_KIND_ID && any_protect && !f_last && !clear
      |=> sum_q == 16'($past(sum_q) + $past(f_data)))
      else $error("id word missing while protected");
   clear_zero_a: assert property ( // [RL12]
      clear |=> sum_q == 16'h0000 && checksum == 16'h0000 && !done)
      else $error("clear did not zero sum");
   done_result_a: assert property ( // [RL2]
      take && f_last && !clear
      |=> done && checksum == 16'($past(sum_q) + $past(addend)))
      else $error("done without final sum");
   wrap_low16_a: assert property ( // [RL6]
      take && !f_last && !clear && ({1'b0, sum_q} + {1'b0, addend}) > 17'h0FFFF
      |=> sum_q < $past(sum_q))
      else $error("carry not dropped");

   // ************************************************************
   // Addend and stream checks
   // ************************************************************
   prog_addend_a: assert property ( // [RL4]
      take && f_kind == PCS_KIND_PROG |-> addend == f_data)
      else $error("program addend not whole word");
   eeprom_addend_a: assert property ( // [RL3]
      take && f_kind == PCS_KIND_EEPROM |-> addend == 16'h0000)
      else $error("eeprom word gave an addend");
   cfg_high_zero_a: assert property ( // [RL7]
      take && f_kind == PCS_KIND_CONFIG |-> addend[15:8] == 8'h00)
      else $error("config addend above low byte");
   cfg_exact_a: assert property ( // [RL8]
      take && f_kind == PCS_KIND_CONFIG && idx_ok
      |-> addend[7:0] == (f_data[7:0] & MASK_TABLE[f_idx*8 +: 8]))
      else $error("config byte not masked by table");
   id_addend_a: assert property ( // [RL10]
      take && f_kind == PCS_KIND_ID
      |-> addend == ((block_protect_bit != '1) ? f_data : 16'h0000))
      else $error("id addend ignores protection");
   sum_idle_a: assert property ( // [RL1]
      !take && !clear |=> sum_q == $past(sum_q))
      else $error("sum moved without a word");
   sum_restart_a: assert property ( // [RL12]
      take && f_last |=> sum_q == PCS_SUM_RESET)
      else $error("sum not restarted after last word");
   res_hold_a: assert property ( // [RL2]
      !clear && !(take && f_last) |=> checksum == $past(checksum))
      else $error("checksum changed between results");
   done_cause_a: assert property ( // [RL12]
      done |-> $past(take) && $past(f_last))
      else $error("done without a last word");
   done_value_a: assert property ( // [RL12]
      done |-> checksum == $past(sum_d))
      else $error("done shows stale result");
   ready_clear_a: assert property ( // [RL12]
      clear |-> !word_ready)
      else $error("word accepted during clear");
   ready_full_a: assert property ( // [RL12]
      !buf_in_ready |-> !word_ready)
      else $error("word accepted into full buffer");
   intake_kept_a: assert property ( // [RL1]
      word_valid && word_ready |=> b_valid)
      else $error("accepted word not buffered");

   done_seen_c: cover property (take && f_last ##1 done);
   id_used_c: cover property (take && f_kind == PCS_KIND_ID && any_protect);
   stall_c: cover property (word_valid && !word_ready && !clear);
   cfg_last_c: cover property (take && f_kind == PCS_KIND_CONFIG &&
                               f_idx == 4'hD);
   cfg_idx_c: cover property (cfg_idx_q == 4'hD);

endmodule : pcs_checksum

// ---- src/pcs_pkg.sv ----
// Constants and types for the program image checksum block.
// Assumes a single clock domain; no software-visible registers.
package pcs_pkg;

   // ************************************************************
   // Widths and counts
   // ************************************************************
   localparam int PCS_SUM_W      = 16;
   localparam int PCS_CFG_W      = 8;
   localparam int PCS_CFG_COUNT  = 14;
   localparam int PCS_IDX_W      = 4;
   localparam int PCS_BLK_COUNT  = 4;
   localparam int PCS_BUF_DEPTH  = 2;
   localparam int PCS_BUF_W      = 19;

   // ************************************************************
   // Word kinds on the input stream
   // ************************************************************
   typedef enum logic [1:0]
   {
      PCS_KIND_PROG   = 2'h0,
      PCS_KIND_CONFIG = 2'h1,
      PCS_KIND_ID     = 2'h2,
      PCS_KIND_EEPROM = 2'h3
   } pcs_kind_t;

   // ************************************************************
   // Buffered word layout: {last, kind, data}
   // ************************************************************
   localparam int PCS_F_DATA_LSB = 0;
   localparam int PCS_F_KIND_LSB = 16;
   localparam int PCS_F_LAST_BIT = 18;

   // ************************************************************
   // Reset values and default mask table (word 0 in low byte)
   // ************************************************************
   localparam logic [15:0] PCS_SUM_RESET = 16'h0000;
   localparam logic [111:0] PCS_MASK_DEFAULT =
      112'h40_0F_E0_0F_C0_0F_00_C5_87_00_1F_1F_CF_00;

endpackage : pcs_pkg

// ---- tb/pcs_seq_model.sv ----
// Behavioural sequencer that streams image words with valid/ready.
// Assumes the bench loads words through push and runs clk_sys.
`timescale 1ns/10ps
module pcs_seq_model
   import pcs_pkg::*;
(
   // Clock
   input  wire logic                 clk_sys,
   // Word stream
   output      logic                 word_valid,
   input  wire logic                 word_ready,
   output      logic [15:0]          word_data,
   output      logic [1:0]           word_kind,
   output      logic [PCS_IDX_W-1:0] config_index,
   output      logic                 word_last
);
   logic [22:0] pend_q[$];
   int          gap;
   int          idle_cnt;

   // Queue one word as {last, kind, index, data}
   task automatic push(input logic l, input logic [1:0] k,
                       input logic [3:0] i, input logic [15:0] d);
      pend_q.push_back({l, k, i, d});
   endtask : push

   // Offer words in order, hold until taken, scramble lines when idle
   initial
   begin
      word_valid = 1'b0;
      {word_last, word_kind, config_index, word_data} = 23'h0;
      gap = 0;
      idle_cnt = 0;
      forever
      begin
         @(negedge clk_sys);
         if (pend_q.size() == 0 || idle_cnt < gap)
         begin
            word_valid = 1'b0;
            {word_last, word_kind, config_index, word_data} =
               ~{word_last, word_kind, config_index, word_data};
            idle_cnt++;
         end
         else
         begin
            {word_last, word_kind, config_index, word_data} = pend_q[0];
            word_valid = 1'b1;
            do @(posedge clk_sys); while (word_ready !== 1'b1);
            void'(pend_q.pop_front());
            idle_cnt = 0;
         end
      end
   end
endmodule : pcs_seq_model

// ---- tb/tb_program_image_checksum.sv ----
// Self-checking bench for the program image checksum block.
// Assumes the sequencer model and the design sources are compiled first.
`timescale 1ns/10ps
module tb_program_image_checksum
   import pcs_pkg::*;
;
   logic                 clk_sys;
   logic                 rstn;
   logic                 clear;
   logic [3:0]           block_protect_bit;
   logic                 word_valid;
   logic                 word_ready;
   logic [15:0]          word_data;
   logic [1:0]           word_kind;
   logic [PCS_IDX_W-1:0] config_index;
   logic                 word_last;
   logic [15:0]          checksum;
   logic                 done;
   int                   num_errors;
   int                   num_checks;

   // ************************************************************
   // Clock, design and sequencer
   // ************************************************************
   initial clk_sys = 1'b0;
   always #50 clk_sys = ~clk_sys;

   pcs_checksum dut_u (.clk_sys(clk_sys), .rstn(rstn), .clear(clear),
      .block_protect_bit(block_protect_bit), .word_valid(word_valid),
      .word_ready(word_ready), .word_data(word_data),
      .word_kind(word_kind), .config_index(config_index),
      .word_last(word_last), .checksum(checksum), .done(done));

   pcs_seq_model seq_u (.clk_sys(clk_sys), .word_valid(word_valid),
      .word_ready(word_ready), .word_data(word_data),
      .word_kind(word_kind), .config_index(config_index),
      .word_last(word_last));

   // ************************************************************
   // Compare and helper tasks
   // ************************************************************
   task automatic check_sum(input logic [15:0] got, input logic [15:0] exp,
                            input string what);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check_sum

   task automatic check_bit(input logic got, input logic exp,
                            input string what);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t: %s got %b exp %b", $time, what, got, exp);
      end
   endtask : check_bit

   // Wait bounded for the done pulse, then judge the result
   task automatic wait_done(input logic [15:0] exp);
      int n;
      n = 0;
      // Step past an edge first; the last test's pulse may still stand
      do
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      while (done !== 1'b1 && n < 40);
      check_bit(done, 1'b1, "done pulse");
      check_sum(checksum, exp, "checksum");
      @(negedge clk_sys);
   endtask : wait_done

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_prog();
      seq_u.push(1'b0, PCS_KIND_PROG, 4'h0, 16'hFFFF);
      seq_u.push(1'b0, PCS_KIND_EEPROM, 4'h0, 16'h1234);
      seq_u.push(1'b0, PCS_KIND_PROG, 4'h0, 16'h0003);
      seq_u.push(1'b0, PCS_KIND_EEPROM, 4'h0, 16'hABCD);
      seq_u.push(1'b1, PCS_KIND_PROG, 4'h0, 16'h8000);
      wait_done(16'h8002);
      $display("t_prog finished");
   endtask : t_prog

   task automatic t_config();
      logic [15:0] e;
      e = 16'h0000;
      for (int i = 0; i < 16; i++)
      begin
         seq_u.push(i == 15, PCS_KIND_CONFIG, 4'(i), 16'hFFFF);
         if (i < 14)
            e = e + 16'(PCS_MASK_DEFAULT[i*8 +: 8]);
      end
      wait_done(e);
      $display("t_config finished");
   endtask : t_config

   task automatic t_id();
      logic [3:0] pat [5];
      pat = '{4'hF, 4'hE, 4'hD, 4'hB, 4'h7};
      for (int p = 0; p < 5; p++)
      begin
         block_protect_bit = pat[p];
         seq_u.gap = p;
         seq_u.push(1'b0, PCS_KIND_PROG, 4'h0, 16'h0100);
         seq_u.push(1'b0, PCS_KIND_ID, 4'h0, 16'h0011);
         seq_u.push(1'b1, PCS_KIND_ID, 4'h0, 16'h0022);
         wait_done(pat[p] == 4'hF ? 16'h0100 : 16'h0133);
      end
      seq_u.gap = 0;
      $display("t_id finished");
   endtask : t_id

   task automatic t_clear();
      seq_u.push(1'b0, PCS_KIND_PROG, 4'h0, 16'h1000);
      repeat (5) @(negedge clk_sys);
      clear = 1'b1;
      seq_u.push(1'b1, PCS_KIND_PROG, 4'h0, 16'h0042);
      repeat (3) @(negedge clk_sys);
      check_bit(word_ready, 1'b0, "ready in clear");
      check_sum(checksum, 16'h0000, "cleared sum");
      clear = 1'b0;
      wait_done(16'h0042);
      $display("t_clear finished");
   endtask : t_clear

   // Reset, run the scenarios, give the verdict
   initial
   begin
      num_errors = 0;
      num_checks = 0;
      rstn = 1'b0;
      clear = 1'b0;
      block_protect_bit = 4'hF;
      repeat (10) @(negedge clk_sys);
      rstn = 1'b1;
      check_bit(word_ready, 1'b0, "ready in reset");
      check_bit(done, 1'b0, "done in reset");
      check_sum(checksum, 16'h0000, "sum in reset");
      t_prog();
      t_config();
      t_id();
      t_clear();
      wrap_up();
   end

   // Watchdog, far beyond the expected run of some 100 cycles
   initial
   begin
      #300000;
      num_errors++;
      wrap_up();
   end
endmodule : tb_program_image_checksum
